// ---- shared/hdsc_pkg.sv ----
// shared constants for the half-duplex serial command port
// assumes an apb slave port with 12-bit byte addresses and 32-bit data
package hdsc_pkg;

    // apb register byte offsets
    localparam logic [11:0] OFS_FRAME_CONTROL   = 12'h000;
    localparam logic [11:0] OFS_MODE_CONTROL    = 12'h004;
    localparam logic [11:0] OFS_DATA_WINDOW     = 12'h008;
    localparam logic [11:0] OFS_STATUS_FLAGS    = 12'h00C;
    localparam logic [11:0] OFS_CLOCK_PRESCALE  = 12'h010;
    localparam logic [11:0] OFS_IRQ_ENABLE_MASK = 12'h014;
    localparam logic [11:0] OFS_RAW_IRQ_STATUS  = 12'h018;
    localparam logic [11:0] OFS_MASKED_IRQ_STAT = 12'h01C;
    localparam logic [11:0] OFS_IRQ_CLEAR       = 12'h020;

    // reset values of the implemented bits
    localparam logic [15:0] FRAME_CONTROL_RST   = 16'h000F;
    localparam logic [4:0]  MODE_CONTROL_RST    = 5'h00;
    localparam logic [7:0]  CLOCK_PRESCALE_RST  = 8'h00;
    localparam logic [3:0]  IRQ_ENABLE_MASK_RST = 4'h0;
    localparam logic [3:0]  RAW_IRQ_STATUS_VAL  = 4'h8;

    // field positions
    localparam int unsigned WIDTH_LSB     = 0;
    localparam int unsigned WIDTH_MSB     = 3;
    localparam int unsigned DIVISOR_LSB   = 8;
    localparam int unsigned DIVISOR_MSB   = 15;
    localparam int unsigned MODE_EN_BIT   = 1;
    localparam int unsigned MODE_CONT_BIT = 4;
    localparam int unsigned ST_TFE_BIT    = 0;
    localparam int unsigned ST_TNF_BIT    = 1;
    localparam int unsigned ST_RNE_BIT    = 2;
    localparam int unsigned ST_RFF_BIT    = 3;
    localparam int unsigned ST_BSY_BIT    = 4;

    // fifo and shifter geometry
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned PTR_W      = 3;
    localparam int unsigned CNT_W      = 4;
    localparam int unsigned WORD_W     = 16;
    localparam int unsigned CTRL_W     = 8;
    localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 4'h8;
    localparam logic [3:0]  CTRL_LAST_BIT = 4'h7;
    localparam logic [7:0]  MIN_PRESCALE  = 8'h02;

    // frame engine states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_CTRL  = 3'b010,
        ST_WAIT  = 3'b011,
        ST_REPLY = 3'b100,
        ST_END   = 3'b101
    } hdsc_state_t;

endpackage : hdsc_pkg

// ---- src/hdsc_fifo_mem.sv ----
// word store for one fifo of the serial command port
// assumes pointers are kept by the caller; one write and one read address per cycle
`timescale 1ns/100ps
`default_nettype none

module hdsc_fifo_mem
    import hdsc_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              nrst_i,
    input  wire logic              wr_en_i,
    input  wire logic [PTR_W-1:0]  wr_addr_i,
    input  wire logic [WORD_W-1:0] wr_data_i,
    input  wire logic [PTR_W-1:0]  rd_addr_i,
    output logic      [WORD_W-1:0] rd_data_o
);

    typedef struct packed {
        logic [FIFO_DEPTH-1:0][WORD_W-1:0] cells;
        logic [WORD_W-1:0]                 rd;
    } hdsc_mem_t;

    hdsc_mem_t m_q;
    hdsc_mem_t m_d;

    // write plus registered read; a write to the read slot is forwarded so
    // a freshly pushed word is never read stale
    always_comb begin
        m_d = m_q;
        if (wr_en_i) begin
            m_d.cells[wr_addr_i] = wr_data_i;
        end
        m_d.rd = (wr_en_i && (wr_addr_i == rd_addr_i)) ? wr_data_i : m_q.cells[rd_addr_i];
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            m_q <= '0;
        end else begin
            m_q <= m_d;
        end
    end

    assign rd_data_o = m_q.rd;

endmodule : hdsc_fifo_mem

`default_nettype wire

// ---- src/hdsc_port.sv ----
// half-duplex command/response serial master with apb register access
// assumes SI_I is asynchronous to SYS_CLK_I; the slave keeps its own timing
`timescale 1ns/100ps
`default_nettype none

module hdsc_port
    import hdsc_pkg::*;
(
    input  wire logic        SYS_CLK_I,
    input  wire logic        NRST_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [11:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic        SI_I,
    output logic             SK_O,
    output logic             CS_N_O,
    output logic             SO_O
);

    typedef struct packed {
        logic [15:0]       frame_ctl;
        logic [4:0]        mode_ctl;
        logic [7:0]        prescale;
        logic [3:0]        irq_mask;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
        logic [PTR_W-1:0]  tx_wr;
        logic [PTR_W-1:0]  tx_rd;
        logic [CNT_W-1:0]  tx_cnt;
        logic [PTR_W-1:0]  rx_wr;
        logic [PTR_W-1:0]  rx_rd;
        logic [CNT_W-1:0]  rx_cnt;
        hdsc_state_t       st;
        logic [14:0]       div_cnt;
        logic              tick;
        logic              sk;
        logic              cs_n;
        logic              so;
        logic [CTRL_W-1:0] tx_sh;
        logic [WORD_W-1:0] rx_sh;
        logic [3:0]        bit_cnt;
        logic              last;
        logic              si_s1;
        logic              si_s2;
    } hdsc_regs_t;

    hdsc_regs_t        r_q;
    hdsc_regs_t        r_d;
    logic              tx_push;
    logic              tx_pop;
    logic              rx_push;
    logic              rx_pop;
    logic [WORD_W-1:0] tx_rdata;
    logic [WORD_W-1:0] rx_rdata;
    logic [14:0]       half;
    logic              apb_done;
    logic              rx_room;
    logic              port_en;

    // half a serial clock period in bus clocks; prescale below two acts as two
    function automatic logic [14:0] half_period(input logic [7:0] psc, input logic [7:0] div);
        logic [6:0]  h;
        logic [15:0] p;
        h = (psc < MIN_PRESCALE) ? MIN_PRESCALE[7:1] : psc[7:1];
        p = {9'h000, h} * ({8'h00, div} + 16'h0001);
        return p[14:0];
    endfunction : half_period

    // fifo pointer advance, wraps naturally at the depth
    function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
        return PTR_W'(p + 1'b1);
    endfunction : ptr_next

    // only aligned, mapped word offsets answer without error
    function automatic logic addr_hit(input logic [11:0] a);
        case (a)
            OFS_FRAME_CONTROL, OFS_MODE_CONTROL, OFS_DATA_WINDOW,
            OFS_STATUS_FLAGS, OFS_CLOCK_PRESCALE, OFS_IRQ_ENABLE_MASK,
            OFS_RAW_IRQ_STATUS, OFS_MASKED_IRQ_STAT, OFS_IRQ_CLEAR: begin
                return 1'b1;
            end
            default: begin
                return 1'b0;
            end
        endcase
    endfunction : addr_hit

    // bus and frame engine helpers shared by the comb process
    assign half     = half_period(r_q.prescale, r_q.frame_ctl[DIVISOR_MSB:DIVISOR_LSB]);
    assign apb_done = PSEL_I && PENABLE_I && r_q.pready;
    assign rx_room  = (r_q.rx_cnt != FIFO_FULL_CNT);
    assign port_en  = r_q.mode_ctl[MODE_EN_BIT];

    // transmit and receive word stores
    hdsc_fifo_mem u_tx_mem (
        .clk_i     (SYS_CLK_I),
        .nrst_i    (NRST_I),
        .wr_en_i   (tx_push),
        .wr_addr_i (r_q.tx_wr),
        .wr_data_i (PWDATA_I[WORD_W-1:0]),
        .rd_addr_i (r_q.tx_rd),
        .rd_data_o (tx_rdata)
    );

    hdsc_fifo_mem u_rx_mem (
        .clk_i     (SYS_CLK_I),
        .nrst_i    (NRST_I),
        .wr_en_i   (rx_push),
        .wr_addr_i (r_q.rx_wr),
        .wr_data_i (r_q.rx_sh),
        .rd_addr_i (r_q.rx_rd),
        .rd_data_o (rx_rdata)
    );

    // whole next-state logic: bus slave, divider, frame engine, fifo pointers
    always_comb begin
        r_d     = r_q;
        tx_push = 1'b0;
        tx_pop  = 1'b0;
        rx_push = 1'b0;
        rx_pop  = 1'b0;

        // two-flop synchroniser for the reply line
        r_d.si_s1 = SI_I;
        r_d.si_s2 = r_q.si_s1;

        // apb: one wait state, so read data can come from a register
        r_d.pready = PSEL_I && PENABLE_I && !r_q.pready;
        if (PSEL_I && PENABLE_I && !r_q.pready) begin
            r_d.pslverr = !addr_hit(PADDR_I);
            r_d.prdata  = '0; // reserved and unmapped bits read zero
            case (PADDR_I)
                OFS_FRAME_CONTROL: begin
                    r_d.prdata[15:0] = r_q.frame_ctl;
                end
                OFS_MODE_CONTROL: begin
                    r_d.prdata[4:0] = r_q.mode_ctl;
                end
                OFS_DATA_WINDOW: begin
                    r_d.prdata[WORD_W-1:0] = (r_q.rx_cnt != '0) ? rx_rdata : '0;
                end
                OFS_STATUS_FLAGS: begin
                    r_d.prdata[ST_TFE_BIT] = (r_q.tx_cnt == '0);
                    r_d.prdata[ST_TNF_BIT] = (r_q.tx_cnt != FIFO_FULL_CNT);
                    r_d.prdata[ST_RNE_BIT] = (r_q.rx_cnt != '0);
                    r_d.prdata[ST_RFF_BIT] = !rx_room;
                    r_d.prdata[ST_BSY_BIT] = (r_q.st != ST_IDLE);
                end
                OFS_CLOCK_PRESCALE: begin
                    r_d.prdata[7:0] = r_q.prescale;
                end
                OFS_IRQ_ENABLE_MASK: begin
                    r_d.prdata[3:0] = r_q.irq_mask;
                end
                OFS_RAW_IRQ_STATUS: begin
                    r_d.prdata[3:0] = RAW_IRQ_STATUS_VAL;
                end
                OFS_MASKED_IRQ_STAT: begin
                    r_d.prdata[3:0] = RAW_IRQ_STATUS_VAL & r_q.irq_mask;
                end
                default: begin
                    r_d.prdata = '0;
                end
            endcase
        end

        // register writes and fifo side effects take effect at the completing edge
        if (apb_done && PWRITE_I) begin
            case (PADDR_I)
                OFS_FRAME_CONTROL: begin
                    r_d.frame_ctl = PWDATA_I[15:0];
                end
                OFS_MODE_CONTROL: begin
                    r_d.mode_ctl = PWDATA_I[4:0];
                end
                OFS_DATA_WINDOW: begin
                    tx_push = (r_q.tx_cnt != FIFO_FULL_CNT);
                end
                OFS_CLOCK_PRESCALE: begin
                    r_d.prescale = PWDATA_I[7:0];
                end
                OFS_IRQ_ENABLE_MASK: begin
                    r_d.irq_mask = PWDATA_I[3:0];
                end
                default: begin
                    r_d.mode_ctl = r_q.mode_ctl; // read-only and clear offsets ignore writes
                end
            endcase
        end
        if (apb_done && !PWRITE_I && (PADDR_I == OFS_DATA_WINDOW)) begin
            rx_pop = (r_q.rx_cnt != '0);
        end

        // half-period divider; held in idle so the first edge is a full half away
        if (r_q.st == ST_IDLE) begin
            r_d.div_cnt = '0;
            r_d.tick    = 1'b0;
        end else if (r_q.div_cnt == 15'(half - 15'h0001)) begin
            r_d.div_cnt = '0;
            r_d.tick    = 1'b1;
        end else begin
            r_d.div_cnt = 15'(r_q.div_cnt + 15'h0001);
            r_d.tick    = 1'b0;
        end

        // frame engine; every serial edge happens on a registered tick
        case (r_q.st)
            ST_IDLE: begin
                r_d.sk   = 1'b0;
                r_d.cs_n = 1'b1;
                r_d.so   = 1'b0;
                if (port_en && (r_q.tx_cnt != '0)) begin
                    r_d.st = ST_START;
                end
            end
            ST_START: begin
                if (r_q.tick) begin
                    r_d.cs_n    = 1'b0;
                    r_d.tx_sh   = tx_rdata[CTRL_W-1:0];
                    r_d.so      = tx_rdata[CTRL_W-1];
                    tx_pop      = 1'b1;
                    r_d.bit_cnt = '0;
                    r_d.st      = ST_CTRL;
                end
            end
            ST_CTRL: begin
                // both edges, SO_O moves on falls; the reply line is not looked at here
                if (r_q.tick && !r_q.sk) begin
                    r_d.sk = 1'b1;
                end else if (r_q.tick) begin
                    r_d.sk = 1'b0;
                    if (r_q.bit_cnt == CTRL_LAST_BIT) begin
                        r_d.so = 1'b0;
                        r_d.st = ST_WAIT;
                    end else begin
                        r_d.tx_sh   = {r_q.tx_sh[CTRL_W-2:0], 1'b0};
                        r_d.so      = r_q.tx_sh[CTRL_W-2];
                        r_d.bit_cnt = 4'(r_q.bit_cnt + 4'h1);
                    end
                end
            end
            ST_WAIT: begin
                // one idle clock lets the slave decode the control word
                if (r_q.tick && !r_q.sk) begin
                    r_d.sk = 1'b1;
                end else if (r_q.tick) begin
                    r_d.sk      = 1'b0;
                    r_d.rx_sh   = '0;
                    r_d.bit_cnt = '0;
                    r_d.st      = ST_REPLY;
                end
            end
            ST_REPLY: begin
                if (r_q.tick && !r_q.sk) begin
                    r_d.sk    = 1'b1;
                    r_d.rx_sh = {r_q.rx_sh[WORD_W-2:0], r_q.si_s2};
                    r_d.last  = (r_q.bit_cnt == r_q.frame_ctl[WIDTH_MSB:WIDTH_LSB]);
                end else if (r_q.tick) begin
                    r_d.sk = 1'b0;
                    if (r_q.last && port_en && r_q.mode_ctl[MODE_CONT_BIT] && (r_q.tx_cnt != '0)) begin
                        // back to back: select stays low, next control byte follows at once
                        rx_push     = rx_room;
                        r_d.last    = 1'b0;
                        r_d.tx_sh   = tx_rdata[CTRL_W-1:0];
                        r_d.so      = tx_rdata[CTRL_W-1];
                        tx_pop      = 1'b1;
                        r_d.bit_cnt = '0;
                        r_d.st      = ST_CTRL;
                    end else if (r_q.last) begin
                        r_d.last = 1'b0;
                        r_d.st   = ST_END;
                    end else begin
                        r_d.bit_cnt = 4'(r_q.bit_cnt + 4'h1);
                    end
                end
            end
            ST_END: begin
                // deselect one full period after the last rising edge
                if (r_q.tick) begin
                    r_d.cs_n = 1'b1;
                    rx_push  = rx_room;
                    r_d.st   = ST_IDLE;
                end
            end
            default: begin
                r_d.st = ST_IDLE;
            end
        endcase

        // fifo bookkeeping; a word arriving at a full receive fifo is dropped
        if (tx_push) begin
            r_d.tx_wr = ptr_next(r_q.tx_wr);
        end
        if (tx_pop) begin
            r_d.tx_rd = ptr_next(r_q.tx_rd);
        end
        r_d.tx_cnt = CNT_W'(r_q.tx_cnt + {3'h0, tx_push} - {3'h0, tx_pop});
        if (rx_push) begin
            r_d.rx_wr = ptr_next(r_q.rx_wr);
        end
        if (rx_pop) begin
            r_d.rx_rd = ptr_next(r_q.rx_rd);
        end
        r_d.rx_cnt = CNT_W'(r_q.rx_cnt + {3'h0, rx_push} - {3'h0, rx_pop});
    end

    // state register; reset loads constants only
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            r_q           <= '0;
            r_q.frame_ctl <= FRAME_CONTROL_RST;
            r_q.mode_ctl  <= MODE_CONTROL_RST;
            r_q.prescale  <= CLOCK_PRESCALE_RST;
            r_q.irq_mask  <= IRQ_ENABLE_MASK_RST;
            r_q.st        <= ST_IDLE;
            r_q.cs_n      <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    // all outputs straight from flops
    assign PRDATA_O  = r_q.prdata;
    assign PREADY_O  = r_q.pready;
    assign PSLVERR_O = r_q.pslverr;
    assign SK_O      = r_q.sk;
    assign CS_N_O    = r_q.cs_n;
    assign SO_O      = r_q.so;

endmodule : hdsc_port

`default_nettype wire

// ---- testbench/hdsc_checker.sv ----
// checker: apb answer timing and serial frame shape of hdsc_port
// assumes a bind to hdsc_port and that link settings change only while idle
`timescale 1ns/100ps
`default_nettype none
module hdsc_checker
    import hdsc_pkg::*;
(
    input wire logic        SYS_CLK_I,
    input wire logic        NRST_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    input wire logic        SI_I,
    input wire logic        SK_O,
    input wire logic        CS_N_O,
    input wire logic        SO_O
);
    logic [15:0] cnt_q;
    logic [15:0] half;
    logic [7:0]  div_q;
    logic [7:0]  pre_q;
    logic [7:0]  pe;
    logic [3:0]  wid_q;
    logic [5:0]  rise_q;
    logic        cont_q;
    logic        sk_q;
    logic        cs_q;
    logic        wr_ok;
    logic        unmap;
    // shadow of the divider; small prescale acts as 2, odd rounds down
    assign wr_ok = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
    assign unmap = (PADDR_I > OFS_IRQ_CLEAR) || (PADDR_I[1:0] != 2'h0);
    assign pe    = (pre_q < MIN_PRESCALE) ? MIN_PRESCALE : pre_q;
    assign half  = {9'h000, pe[7:1]} * ({8'h00, div_q} + 16'h0001);
    // cycles since the last link edge, rises seen while selected
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            cnt_q  <= 16'h0000;
            div_q  <= 8'h00;
            pre_q  <= 8'h00;
            wid_q  <= 4'hF;
            rise_q <= 6'h00;
            cont_q <= 1'h0;
            sk_q   <= 1'h0;
            cs_q   <= 1'h1;
        end else begin
            sk_q  <= SK_O;
            cs_q  <= CS_N_O;
            cnt_q <= (SK_O != sk_q || CS_N_O != cs_q) ? 16'h0001 : cnt_q + 16'h0001;
            if (!CS_N_O && cs_q) begin
                rise_q <= 6'h00;
            end else if (SK_O && !sk_q) begin
                rise_q <= rise_q + 6'h01;
            end
            if (wr_ok && PADDR_I == OFS_FRAME_CONTROL) begin
                wid_q <= PWDATA_I[WIDTH_MSB:WIDTH_LSB];
                div_q <= PWDATA_I[DIVISOR_MSB:DIVISOR_LSB];
            end
            if (wr_ok && PADDR_I == OFS_CLOCK_PRESCALE) begin
                pre_q <= PWDATA_I[7:0];
            end
            if (wr_ok && PADDR_I == OFS_MODE_CONTROL) begin
                cont_q <= PWDATA_I[MODE_CONT_BIT];
            end
        end
    end
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!NRST_I);
    sequence s_access;
        PSEL_I && PENABLE_I && !PREADY_O;
    endsequence
    sequence s_answer;
        PREADY_O ##1 !PREADY_O;
    endsequence
    chk_apb_one_wait: assert property (s_access |=> s_answer)
        else $error("apb answer not in second access cycle");
    chk_apb_err_map: assert property (PREADY_O |-> PSLVERR_O == unmap)
        else $error("error response does not match address");
    chk_idle_levels: assert property (CS_N_O && $past(CS_N_O) |-> !SK_O && !SO_O)
        else $error("idle line levels wrong");
    chk_sk_selected: assert property (SK_O |-> !CS_N_O)
        else $error("clock high while deselected");
    chk_select_hold: assert property ($fell(CS_N_O) |-> (!CS_N_O) [*8])
        else $error("select released too early");
    chk_half_period: assert property (SK_O != sk_q |-> cnt_q == half)
        else $error("clock half period wrong");
    chk_deselect_time: assert property ($rose(CS_N_O) |-> cnt_q == half && !SK_O)
        else $error("select rise not one half period after last fall");
    chk_frame_bits: assert property ($rose(CS_N_O) && !cont_q |-> rise_q == {2'h0, wid_q} + 6'h0A)
        else $error("clock count of single frame wrong");
    chk_so_on_fall: assert property ($changed(SO_O) |-> $fell(SK_O) || $changed(CS_N_O))
        else $error("data out changed off a falling clock");
endmodule : hdsc_checker
bind hdsc_port hdsc_checker i_hdsc_checker (
    .SYS_CLK_I(SYS_CLK_I), .NRST_I(NRST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .SI_I(SI_I), .SK_O(SK_O),
    .CS_N_O(CS_N_O), .SO_O(SO_O)
);
`default_nettype wire

// ---- testbench/hdsc_slave_model.sv ----
// behavioural off-chip slave: takes a control byte, answers {~ctrl, ctrl} low bits
// assumes the bench tells it the reply length in bits
`timescale 1ns/100ps
`default_nettype none
module hdsc_slave_model (
    input  wire logic       clk_i,
    input  wire logic       sk_i,
    input  wire logic       cs_n_i,
    input  wire logic       so_i,
    input  wire logic [4:0] n_bits_i,
    output logic            si_o
);
    int          rises = 0;
    logic [7:0]  ctrl  = 8'h00;
    logic [15:0] word  = 16'h0000;
    logic        drive = 1'h0;
    logic        noise = 1'h0;
    // a released line floats: show a changing pattern, never a held value
    always @(posedge clk_i) noise <= ~noise;
    assign si_o = drive ? word[15] : noise;
    // select falling starts a fresh count; rising releases the line
    always @(negedge cs_n_i) rises = 0;
    always @(posedge cs_n_i) drive = 1'h0;
    // control bits taken on rises; the ninth rise is the decode wait
    always @(posedge sk_i) begin
        if (!cs_n_i && rises < 8) ctrl = {ctrl[6:0], so_i};
        if (!cs_n_i) rises++;
    end
    // reply bits launched on falls, msb first, released after the last
    always @(negedge sk_i) begin
        if (rises == 9) begin
            word  = {~ctrl, ctrl} << (16 - n_bits_i);
            drive = 1'h1;
        end else if (rises == 9 + n_bits_i) begin
            drive = 1'h0;
            rises = 0;
        end else if (rises > 9) begin
            word = word << 1;
        end
    end
endmodule : hdsc_slave_model
`default_nettype wire

// ---- testbench/hdsc_port_tb_top.sv ----
// bench for hdsc_port: apb tasks set registers, the slave model answers frames
// assumes the checker bind and the slave model are compiled first
`timescale 1ns/100ps
`default_nettype none
module hdsc_port_tb_top
    import hdsc_pkg::*;
();
    logic        clk    = 1'h0;
    logic        nrst   = 1'h0;
    logic        psel   = 1'h0;
    logic        pen    = 1'h0;
    logic        pwr    = 1'h0;
    logic [11:0] paddr  = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        si;
    logic        sk;
    logic        cs_n;
    logic        so;
    logic [4:0]  nbits  = 5'h10;
    int          failures = 0;
    int          checks   = 0;
    int          cycles   = 0;
    int          cs_rises = 0;
    logic [31:0] rst_v [8] = '{32'hF, 32'h0, 32'h0, 32'h3, 32'h0, 32'h0, 32'h8, 32'h0};
    logic [3:0]  wids [3]  = '{4'h3, 4'h7, 4'hF};
    logic [7:0]  ctls [3]  = '{8'h96, 8'h3C, 8'hC3};

    hdsc_port i_hdsc_port (
        .SYS_CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .SI_I(si), .SK_O(sk), .CS_N_O(cs_n), .SO_O(so)
    );
    hdsc_slave_model i_hdsc_slave_model (
        .clk_i(clk), .sk_i(sk), .cs_n_i(cs_n), .so_i(so), .n_bits_i(nbits), .si_o(si)
    );

    // 100 MHz clock; select rises counted to tell single from continuous
    always #5 clk = ~clk;
    always @(posedge cs_n) cs_rises++;
    // hang guard, far above the fewer than a thousand cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (failures == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // one apb transfer; request held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge clk);
        psel   <= 1'h1;
        pen    <= 1'h0;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        pen  <= 1'h0;
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        xfer(1'h1, a, d, r, e);
    endtask : wr

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        xfer(1'h0, a, 32'h0, r, e);
        chk(name, x, r);
        chk(name, {31'h0, xe}, {31'h0, e});
    endtask : rd_chk

    // poll status until the engine is idle with nothing left to send
    task automatic wait_idle();
        logic [31:0] r;
        logic        e;
        for (int i = 0; i < 200; i++) begin
            xfer(1'h0, OFS_STATUS_FLAGS, 32'h0, r, e);
            if (r[ST_BSY_BIT] === 1'h0 && r[ST_TFE_BIT] === 1'h1) break;
        end
    endtask : wait_idle

    function automatic logic [31:0] reply_of(input logic [7:0] c, input logic [4:0] n);
        logic [15:0] f;
        f = {~c, c} & (16'hFFFF >> (5'h10 - n));
        return {16'h0000, f};
    endfunction : reply_of

    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'h1;
        // defaults, read-only places and a hole in the map
        for (int i = 0; i < 8; i++) rd_chk("reset", 12'(4 * i), rst_v[i], 1'h0);
        rd_chk("unmapped", 12'h024, 32'h0, 1'h1);
        wr(OFS_STATUS_FLAGS, 32'h0);
        rd_chk("status", OFS_STATUS_FLAGS, 32'h3, 1'h0);
        wr(OFS_IRQ_ENABLE_MASK, 32'hF);
        rd_chk("mask", OFS_IRQ_ENABLE_MASK, 32'hF, 1'h0);
        rd_chk("masked", OFS_MASKED_IRQ_STAT, 32'h8, 1'h0);
        // configure fully before enabling; no byte means no frame
        wr(OFS_FRAME_CONTROL, 32'hF);
        wr(OFS_CLOCK_PRESCALE, 32'h6);
        wr(OFS_MODE_CONTROL, 32'h2);
        repeat (30) @(posedge clk);
        chk("idle select", 32'h1, {31'h0, cs_n});
        // single frames with a 4-bit, an 8-bit and the widest (16-bit) reply
        for (int i = 0; i < 3; i++) begin
            nbits = {1'h0, wids[i]} + 5'h01;
            wr(OFS_FRAME_CONTROL, {28'h0, wids[i]});
            cs_rises = 0;
            wr(OFS_DATA_WINDOW, {24'hFFFFFF, ctls[i]});
            wait_idle();
            rd_chk("reply", OFS_DATA_WINDOW, reply_of(ctls[i], nbits), 1'h0);
            chk("single deselects", 32'h1, cs_rises);
        end
        // two frames back to back, select held low between them
        nbits = 5'h08;
        wr(OFS_CLOCK_PRESCALE, 32'h4);
        wr(OFS_FRAME_CONTROL, 32'h107);
        wr(OFS_MODE_CONTROL, 32'h12);
        cs_rises = 0;
        wr(OFS_DATA_WINDOW, 32'h5A);
        wr(OFS_DATA_WINDOW, 32'hA5);
        wait_idle();
        chk("continuous deselects", 32'h1, cs_rises);
        rd_chk("first reply", OFS_DATA_WINDOW, reply_of(8'h5A, 5'h08), 1'h0);
        rd_chk("second reply", OFS_DATA_WINDOW, reply_of(8'hA5, 5'h08), 1'h0);
        rd_chk("drained", OFS_DATA_WINDOW, 32'h0, 1'h0);
        give_verdict();
    end
endmodule : hdsc_port_tb_top
`default_nettype wire
